// >>> bme_pkg.sv
/*
  Shared constants and types for the break and monitor entry block:
  register offsets, field positions, reset values, link timing, states.
  Assumes a 32-bit APB bus and a 16-bit processor address space.
*/
package bme_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_ADDRESS_HIGH = 8'h04;
  localparam logic [7:0] OFS_ADDRESS_LOW = 8'h08;
  localparam logic [7:0] OFS_AUXILIARY = 8'h0C;
  localparam logic [7:0] OFS_WAIT_STATUS = 8'h10;
  localparam logic [7:0] OFS_FLAG_CONTROL = 8'h14;
  localparam logic [7:0] OFS_MONITOR_STATUS = 8'h18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_MATCH_ENABLE = 7;
  localparam int BIT_BREAK_ACTIVE = 6;
  localparam int BIT_WDOG_OFF = 0;
  localparam int BIT_WAIT_EXIT = 1;
  localparam int BIT_FLAG_CLEAR = 7;
  localparam int BIT_MON_MODE = 0;
  localparam int BIT_MON_INT_OSC = 1;
  localparam int BIT_MON_FORCED = 2;
  localparam int BIT_MON_READY = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_VECTOR_ERASED = 16'hFFFF;

  // ----------------------------------------------------------------
  // break vectors
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_BREAK_USER = 16'hFFFC;
  localparam logic [15:0] VEC_BREAK_MONITOR = 16'hFEFC;

  // ----------------------------------------------------------------
  // monitor link timing: bit times in bus clocks, lengths in bytes and bits
  // ----------------------------------------------------------------
  localparam logic [8:0] BAUD_DIV_EXT = 9'h100;
  localparam logic [8:0] BAUD_DIV_INT = 9'h14F;
  localparam logic [3:0] SECURITY_BYTES = 4'h8;
  localparam logic [3:0] BREAK_BITS = 4'hA;
  localparam logic [3:0] ECHO_HIGH_BITS = 4'h2;
  localparam logic [3:0] RX_LAST_SAMPLE = 4'h9;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    LNK_OFF = 5'b00001,
    LNK_SECURITY = 5'b00010,
    LNK_SEND_BREAK = 5'b00100,
    LNK_READY = 5'b01000,
    LNK_ECHO_HIGH = 5'b10000
  } bme_link_e;

  typedef struct packed {
    logic timer_freeze;
    logic watchdog_disable;
    logic flag_clear_allow;
  } bme_break_ctrl_s;

  typedef struct packed {
    logic monitor_mode;
    logic forced;
    logic internal_osc;
    logic trim_apply;
    logic [7:0] trim_value;
  } bme_mon_entry_s;

endpackage

// >>> bme_top.sv
/*
  Break unit and monitor mode entry logic with an APB register slave.
  Assumes pclk is the bus clock, all inputs are synchronous to it, and
  the pad outside resolves the wired-OR serial pin with a pull-up.
*/
// Behaviour
// - match enable breaks on 16-bit fetch equality
// - address match sets break active bit
// - writing one to break active breaks
// - writing zero clears break active; reset too
// - two byte address registers reset zero
// - timer counter halted during break
// - watchdog off in break when monitor and enabled
// - flags clearable in break only if enabled
// - readable wait-exited-by-break flag
// - no address-match break in wait or stop
// - blank reset vector enters monitor mode
// - normal entry needs test voltage, pin levels
// - blank vector, interrupt low: internal trimmed oscillator
// - mode captured at internal reset rising edge
// - wait for eight security bytes
// - then send ten zero bit break
// - bit time 256 external, 335 internal
// - single wired-OR serial pin with pull-up
// - break forces swi, vector by mode
// - received break: two high bits, echo break
`timescale 1ns/1ns
module bme_top
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] fetch_addr,
  input wire logic fetch_valid,
  input wire logic low_power,
  input wire logic break_state,
  input wire logic wait_exit_break,
  output logic breakpoint_signal,
  output logic force_swi,
  output logic [15:0] break_vector,
  output bme_pkg::bme_break_ctrl_s break_ctrl,
  input wire logic internal_reset_n,
  input wire logic irq_test_voltage,
  input wire logic irq_level,
  input wire logic mode_select_a_pin,
  input wire logic mode_select_b_pin,
  input wire logic [15:0] reset_vector,
  input wire logic [7:0] oscillator_trim_value,
  input wire logic trim_programmed,
  output bme_pkg::bme_mon_entry_s mon_entry,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_oe
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic match_enable_q;
  logic break_active_q;
  logic [7:0] addr_high_q;
  logic [7:0] addr_low_q;
  logic wdog_off_q;
  logic wait_exit_q;
  logic flag_clear_q;
  logic setup;
  logic wr_en;
  logic mapped;
  logic [31:0] rd_mux;
  logic addr_match;
  logic sw_break;
  logic [7:0] mon_status;

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite & pready;

  // ----------------------------------------------------------------
  // apb slave: one wait-free access phase, answered from flops
  // ----------------------------------------------------------------
  always_comb
  begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      bme_pkg::OFS_STATUS_CONTROL:
      begin
        rd_mux[bme_pkg::BIT_MATCH_ENABLE] = match_enable_q;
        rd_mux[bme_pkg::BIT_BREAK_ACTIVE] = break_active_q;
      end
      bme_pkg::OFS_ADDRESS_HIGH: rd_mux[7:0] = addr_high_q;
      bme_pkg::OFS_ADDRESS_LOW: rd_mux[7:0] = addr_low_q;
      bme_pkg::OFS_AUXILIARY: rd_mux[bme_pkg::BIT_WDOG_OFF] = wdog_off_q;
      bme_pkg::OFS_WAIT_STATUS: rd_mux[bme_pkg::BIT_WAIT_EXIT] = wait_exit_q;
      bme_pkg::OFS_FLAG_CONTROL:
        rd_mux[bme_pkg::BIT_FLAG_CLEAR] = flag_clear_q;
      bme_pkg::OFS_MONITOR_STATUS: rd_mux[7:0] = mon_status;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup;
      if (setup)
      begin
        pslverr <= ~mapped;
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // break registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      match_enable_q <= 1'b0;
      addr_high_q <= bme_pkg::RST_BYTE;
      addr_low_q <= bme_pkg::RST_BYTE;
      wdog_off_q <= 1'b0;
      flag_clear_q <= 1'b0;
    end
    else if (wr_en)
    begin
      case (paddr)
        bme_pkg::OFS_STATUS_CONTROL:
          match_enable_q <= pwdata[bme_pkg::BIT_MATCH_ENABLE];
        bme_pkg::OFS_ADDRESS_HIGH: addr_high_q <= pwdata[7:0];
        bme_pkg::OFS_ADDRESS_LOW: addr_low_q <= pwdata[7:0];
        bme_pkg::OFS_AUXILIARY: wdog_off_q <= pwdata[bme_pkg::BIT_WDOG_OFF];
        bme_pkg::OFS_FLAG_CONTROL:
          flag_clear_q <= pwdata[bme_pkg::BIT_FLAG_CLEAR];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // break detection
  // ----------------------------------------------------------------
  // fetch_valid strobes once per processor fetch; frozen bus in low
  // power never strobes it, and low_power masks it anyway
  assign addr_match = match_enable_q & fetch_valid & ~low_power &
    (fetch_addr == {addr_high_q, addr_low_q});
  assign sw_break = wr_en & (paddr == bme_pkg::OFS_STATUS_CONTROL) &
    pwdata[bme_pkg::BIT_BREAK_ACTIVE];

  // a match in the cycle of a clearing write wins over the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      break_active_q <= 1'b0;
    else if (addr_match)
      break_active_q <= 1'b1;
    else if (wr_en && paddr == bme_pkg::OFS_STATUS_CONTROL)
      break_active_q <= pwdata[bme_pkg::BIT_BREAK_ACTIVE];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      breakpoint_signal <= 1'b0;
      force_swi <= 1'b0;
      break_vector <= bme_pkg::VEC_BREAK_USER;
    end
    else
    begin
      breakpoint_signal <= addr_match | sw_break;
      force_swi <= addr_match | sw_break;
      break_vector <= mon_entry.monitor_mode ? bme_pkg::VEC_BREAK_MONITOR
        : bme_pkg::VEC_BREAK_USER;
    end
  end

  // hardware set wins over a clearing write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wait_exit_q <= 1'b0;
    else if (wait_exit_break)
      wait_exit_q <= 1'b1;
    else if (wr_en && paddr == bme_pkg::OFS_WAIT_STATUS)
      wait_exit_q <= pwdata[bme_pkg::BIT_WAIT_EXIT];
  end

  // ----------------------------------------------------------------
  // controls to other modules during break
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      break_ctrl <= '{timer_freeze: 1'b0, watchdog_disable: 1'b0,
        flag_clear_allow: 1'b1};
    else
    begin
      break_ctrl.timer_freeze <= break_state;
      break_ctrl.watchdog_disable <= break_state & wdog_off_q &
        mon_entry.monitor_mode;
      break_ctrl.flag_clear_allow <= ~break_state | flag_clear_q;
    end
  end

  // ----------------------------------------------------------------
  // monitor mode entry
  // ----------------------------------------------------------------
  logic int_rst_prev_q;
  logic vector_blank;
  logic normal_entry;
  logic link_ready_q;

  assign vector_blank = (reset_vector == bme_pkg::RST_VECTOR_ERASED);
  assign normal_entry = irq_test_voltage & serial_in & mode_select_a_pin &
    ~mode_select_b_pin;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_rst_prev_q <= 1'b0;
    else
      int_rst_prev_q <= internal_reset_n;
  end

  // decision taken only at the release edge; pins are ignored after
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mon_entry <= '0;
    else if (internal_reset_n && !int_rst_prev_q)
    begin
      mon_entry.monitor_mode <= normal_entry | vector_blank;
      mon_entry.forced <= ~normal_entry & vector_blank;
      mon_entry.internal_osc <= ~normal_entry & vector_blank &
        ~irq_level;
      mon_entry.trim_apply <= ~normal_entry & vector_blank & ~irq_level &
        trim_programmed;
      mon_entry.trim_value <= oscillator_trim_value;
    end
  end

  always_comb
  begin
    mon_status = 8'h00;
    mon_status[bme_pkg::BIT_MON_MODE] = mon_entry.monitor_mode;
    mon_status[bme_pkg::BIT_MON_INT_OSC] = mon_entry.internal_osc;
    mon_status[bme_pkg::BIT_MON_FORCED] = mon_entry.forced;
    mon_status[bme_pkg::BIT_MON_READY] = link_ready_q;
  end

  // ----------------------------------------------------------------
  // monitor link receiver
  // ----------------------------------------------------------------
  bme_pkg::bme_link_e link_q;
  logic [8:0] bit_div;
  logic rx_act_q;
  logic [8:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic rx_zero_q;
  logic rx_prev_q;
  logic rx_done_q;
  logic rx_brk_q;
  logic rx_listen;

  assign bit_div = mon_entry.internal_osc ? bme_pkg::BAUD_DIV_INT
    : bme_pkg::BAUD_DIV_EXT;
  assign rx_listen = (link_q == bme_pkg::LNK_SECURITY) ||
    (link_q == bme_pkg::LNK_READY);

  // frame of ten samples taken at bit centres, start bit included
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_act_q <= 1'b0;
      rx_cnt_q <= 9'h000;
      rx_bit_q <= 4'h0;
      rx_zero_q <= 1'b0;
      rx_prev_q <= 1'b1;
      rx_done_q <= 1'b0;
      rx_brk_q <= 1'b0;
    end
    else
    begin
      rx_prev_q <= serial_in;
      rx_done_q <= 1'b0;
      rx_brk_q <= 1'b0;
      if (!rx_listen)
        rx_act_q <= 1'b0;
      else if (!rx_act_q)
      begin
        if (rx_prev_q && !serial_in)
        begin
          rx_act_q <= 1'b1;
          rx_cnt_q <= {1'b0, bit_div[8:1]};
          rx_bit_q <= 4'h0;
          rx_zero_q <= 1'b1;
        end
      end
      else if (rx_cnt_q == 9'h000)
      begin
        rx_zero_q <= rx_zero_q & ~serial_in;
        rx_cnt_q <= bit_div - 9'h001;
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == bme_pkg::RX_LAST_SAMPLE)
        begin
          rx_act_q <= 1'b0;
          rx_done_q <= ~(rx_zero_q & ~serial_in);
          rx_brk_q <= rx_zero_q & ~serial_in;
        end
      end
      else
        rx_cnt_q <= rx_cnt_q - 9'h001;
    end
  end

  // ----------------------------------------------------------------
  // monitor link sequencer and transmitter
  // ----------------------------------------------------------------
  logic [8:0] tx_cnt_q;
  logic [3:0] tx_bits_q;
  logic [3:0] sec_cnt_q;
  logic bit_end;

  assign bit_end = (tx_cnt_q == 9'h000);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link_q <= bme_pkg::LNK_OFF;
      tx_cnt_q <= 9'h000;
      tx_bits_q <= 4'h0;
      sec_cnt_q <= 4'h0;
    end
    else if (!mon_entry.monitor_mode)
      link_q <= bme_pkg::LNK_OFF;
    else
    begin
      tx_cnt_q <= bit_end ? bit_div - 9'h001 : tx_cnt_q - 9'h001;
      case (link_q)
        bme_pkg::LNK_OFF:
        begin
          link_q <= bme_pkg::LNK_SECURITY;
          sec_cnt_q <= 4'h0;
        end
        bme_pkg::LNK_SECURITY:
        begin
          if (rx_done_q || rx_brk_q)
          begin
            sec_cnt_q <= sec_cnt_q + 4'h1;
            if (sec_cnt_q == bme_pkg::SECURITY_BYTES - 4'h1)
            begin
              link_q <= bme_pkg::LNK_SEND_BREAK;
              tx_cnt_q <= bit_div - 9'h001;
              tx_bits_q <= 4'h0;
            end
          end
        end
        bme_pkg::LNK_SEND_BREAK:
        begin
          if (bit_end)
          begin
            tx_bits_q <= tx_bits_q + 4'h1;
            if (tx_bits_q == bme_pkg::BREAK_BITS - 4'h1)
              link_q <= bme_pkg::LNK_READY;
          end
        end
        bme_pkg::LNK_READY:
        begin
          if (rx_brk_q)
          begin
            link_q <= bme_pkg::LNK_ECHO_HIGH;
            tx_cnt_q <= bit_div - 9'h001;
            tx_bits_q <= 4'h0;
          end
        end
        bme_pkg::LNK_ECHO_HIGH:
        begin
          if (bit_end)
          begin
            tx_bits_q <= tx_bits_q + 4'h1;
            if (tx_bits_q == bme_pkg::ECHO_HIGH_BITS - 4'h1)
            begin
              link_q <= bme_pkg::LNK_SEND_BREAK;
              tx_bits_q <= 4'h0;
            end
          end
        end
        default: link_q <= bme_pkg::LNK_OFF;
      endcase
    end
  end

  // pin driven only while sending; released otherwise so the pull-up
  // and the host share the wire
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      serial_out <= 1'b1;
      serial_oe <= 1'b0;
      link_ready_q <= 1'b0;
    end
    else
    begin
      link_ready_q <= (link_q == bme_pkg::LNK_READY);
      case (link_q)
        bme_pkg::LNK_SEND_BREAK:
        begin
          serial_out <= 1'b0;
          serial_oe <= 1'b1;
        end
        bme_pkg::LNK_ECHO_HIGH:
        begin
          serial_out <= 1'b1;
          serial_oe <= 1'b1;
        end
        default:
        begin
          serial_out <= 1'b1;
          serial_oe <= 1'b0;
        end
      endcase
    end
  end

endmodule

// >>> bme_top_sva.sv
/*
  Assertion checker for bme_top, watching its ports only.
  Assumes one clock pclk and the asynchronous active-low presetn.
*/
`timescale 1ns/1ns
module bme_top_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [15:0] fetch_addr,
  input wire logic fetch_valid,
  input wire logic low_power,
  input wire logic break_state,
  input wire logic breakpoint_signal,
  input wire logic force_swi,
  input wire logic [15:0] break_vector,
  input wire bme_pkg::bme_break_ctrl_s break_ctrl,
  input wire logic internal_reset_n,
  input wire bme_pkg::bme_mon_entry_s mon_entry,
  input wire logic serial_out,
  input wire logic serial_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] ah_q, al_q;
  logic en_q, wd_q, fc_q, wr, wr1, hit;
  logic [1:0] age_q;
  logic [11:0] low_q;
  // ----------------------------------------------------------------
  // shadow of the control bits written over the bus
  // ----------------------------------------------------------------
  assign wr = psel && penable && pwrite && pready;
  assign wr1 = wr && paddr == bme_pkg::OFS_STATUS_CONTROL && pwdata[6];
  assign hit = fetch_valid && en_q && !low_power &&
    fetch_addr == {ah_q, al_q};
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      {en_q, wd_q, fc_q, ah_q, al_q} <= 19'h0;
    else if (wr)
      case (paddr)
        bme_pkg::OFS_STATUS_CONTROL: en_q <= pwdata[7];
        bme_pkg::OFS_ADDRESS_HIGH: ah_q <= pwdata[7:0];
        bme_pkg::OFS_ADDRESS_LOW: al_q <= pwdata[7:0];
        bme_pkg::OFS_AUXILIARY: wd_q <= pwdata[0];
        bme_pkg::OFS_FLAG_CONTROL: fc_q <= pwdata[7];
        default: ;
      endcase
  // settle counter after reset, length of a low drive on the pin
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      {age_q, low_q} <= 14'h0;
    else
    begin
      age_q <= (age_q == 2'h3) ? age_q : age_q + 2'h1;
      low_q <= (serial_oe && !serial_out) ? low_q + 12'h1 : 12'h0;
    end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_match; hit |=> breakpoint_signal; endproperty
  a_match: assert property (p_match)
    else $error("no break after address match");
  property p_cause; breakpoint_signal |-> $past(hit || wr1); endproperty
  a_cause: assert property (p_cause)
    else $error("break without a cause");
  property p_soft; wr1 |=> breakpoint_signal; endproperty
  a_soft: assert property (p_soft)
    else $error("no break after software write");
  property p_swi; force_swi == breakpoint_signal; endproperty
  a_swi: assert property (p_swi)
    else $error("forced instruction apart from break pulse");
  property p_vec; mon_entry.monitor_mode ##1 mon_entry.monitor_mode
    |-> break_vector == bme_pkg::VEC_BREAK_MONITOR; endproperty
  a_vec: assert property (p_vec)
    else $error("wrong break vector in monitor mode");
  property p_freeze; break_state |=> break_ctrl.timer_freeze; endproperty
  a_freeze: assert property (p_freeze)
    else $error("timer not frozen in break");
  property p_wdog; break_state && wd_q && mon_entry.monitor_mode
    |=> break_ctrl.watchdog_disable; endproperty
  a_wdog: assert property (p_wdog)
    else $error("watchdog not disabled in break");
  property p_flag; $past(break_state) && !$past(fc_q)
    |-> !break_ctrl.flag_clear_allow; endproperty
  a_flag: assert property (p_flag)
    else $error("flags clearable in break while disabled");
  property p_brklen; serial_oe && !serial_out |-> low_q < 12'hD18;
  endproperty
  a_brklen: assert property (p_brklen)
    else $error("low drive on serial pin too long");
  property p_oe; serial_oe |-> mon_entry.monitor_mode; endproperty
  a_oe: assert property (p_oe)
    else $error("serial pin driven outside monitor mode");
  property p_latch; age_q == 2'h3 && internal_reset_n &&
    $past(internal_reset_n) |=> $stable(mon_entry); endproperty
  a_latch: assert property (p_latch)
    else $error("mode changed after latch");
  c_hit: cover property (hit);
  c_drive: cover property ($rose(serial_oe));
  c_intosc: cover property (mon_entry.internal_osc);
endmodule

// >>> bme_host_model.sv
/*
  Host side of the monitor serial link: sends one NRZ frame per go.
  Assumes the bench resolves the pin as wired-OR with a pull-up.
*/
`timescale 1ns/1ns
module bme_host_model (
  input wire logic pclk,
  input wire logic go,
  input wire logic breakpoint_unit,
  input wire logic [7:0] data,
  input wire logic [8:0] div,
  output logic busy,
  output logic drive_low
);
  logic [9:0] sh_q;
  logic [3:0] nb_q;
  logic [8:0] cnt_q;
  initial
  begin
    busy = 1'h0;
    drive_low = 1'h0;
  end
  // ----------------------------------------------------------------
  // start, data lsb first, stop; a break keeps the stop bit low
  // ----------------------------------------------------------------
  always @(posedge pclk)
    if (go && !busy)
    begin
      sh_q <= {~breakpoint_unit, data, 1'h0};
      nb_q <= 4'hA;
      cnt_q <= div - 9'h1;
      busy <= 1'h1;
      drive_low <= 1'h1;
    end
    else if (busy)
    begin
      if (cnt_q != 9'h0)
        cnt_q <= cnt_q - 9'h1;
      else if (nb_q == 4'h1)
      begin
        busy <= 1'h0;
        drive_low <= 1'h0;
      end
      else
      begin
        sh_q <= sh_q >> 1;
        nb_q <= nb_q - 4'h1;
        cnt_q <= div - 9'h1;
        drive_low <= ~sh_q[1];
      end
    end
endmodule

// >>> bme_top_tb_top.sv
/*
  Self-checking bench for bme_top with the serial host model.
  Assumes bme_pkg, bme_top, bme_host_model and bme_top_sva compiled.
*/
`timescale 1ns/1ns
`define CHK(g, e) \
  begin \
    n_tests++; \
    if ((g) !== (e)) \
    begin \
      err_count++; \
      $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end
module bme_top_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, oscillator_trim_value, hdata;
  logic [31:0] pwdata, prdata;
  logic [15:0] fetch_addr, break_vector, reset_vector, a;
  logic fetch_valid, low_power, break_state, wait_exit_break, force_swi;
  logic breakpoint_signal, internal_reset_n, irq_test_voltage, irq_level;
  logic mode_select_a_pin, mode_select_b_pin, trim_programmed, f;
  logic serial_in, serial_out, serial_oe, go, breakpoint_unit, busy, host_low;
  bme_pkg::bme_break_ctrl_s break_ctrl;
  bme_pkg::bme_mon_entry_s mon_entry, me;
  logic [32:0] exp_q[$];
  logic [7:0] cases [5];
  int err_count, n_tests, pulses, n;
  bme_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .fetch_addr, .fetch_valid,
    .low_power, .break_state, .wait_exit_break, .breakpoint_signal,
    .force_swi, .break_vector, .break_ctrl, .internal_reset_n,
    .irq_test_voltage, .irq_level, .mode_select_a_pin,
    .mode_select_b_pin, .reset_vector, .oscillator_trim_value,
    .trim_programmed, .mon_entry, .serial_in, .serial_out, .serial_oe);
  bme_host_model u_host (.pclk, .go, .breakpoint_unit, .data(hdata),
    .div(bme_pkg::BAUD_DIV_INT), .busy, .drive_low(host_low));
  assign serial_in = !(host_low || (serial_oe && !serial_out));
  initial
  begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  // ----------------------------------------------------------------
  // output watcher: pulses and read answers against queued notes
  // ----------------------------------------------------------------
  always @(posedge pclk)
  begin
    if (breakpoint_signal === 1'h1)
      pulses++;
    if (psel && penable && pready && !pwrite)
      `CHK({pslverr, prdata}, exp_q.pop_front())
  end
  task automatic apb(input logic w, input logic [7:0] ad,
    input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1)
      @(posedge pclk);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] d,
    input logic e);
    exp_q.push_back({e, d});
    apb(1'h0, ad, 32'h0);
  endtask
  task automatic fetch(input logic [15:0] ad, input int k);
    fetch_valid <= 1'h1;
    fetch_addr <= ad;
    @(posedge pclk);
    fetch_valid <= 1'h0;
    repeat (3) @(posedge pclk);
    `CHK(pulses, k)
  endtask
  task automatic send(input logic [7:0] d, input logic b);
    hdata <= d;
    breakpoint_unit <= b;
    go <= 1'h1;
    @(posedge pclk);
    go <= 1'h0;
    @(posedge pclk);
    while (busy === 1'h1)
      @(posedge pclk);
    repeat (256) @(posedge pclk);
  endtask
  // first drive level, then low cycles until release
  task automatic meas(output logic fl, output int k);
    int i;
    i = 0;
    k = 0;
    while (serial_oe !== 1'h1 && i < 9000)
    begin
      @(posedge pclk);
      i++;
    end
    fl = serial_out;
    while (serial_oe === 1'h1 && i < 18000)
    begin
      @(posedge pclk);
      i++;
      k += int'(serial_out === 1'h0);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #400000;
    err_count++;
    print_verdict();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, fetch_valid, low_power} = 6'h0;
    {break_state, wait_exit_break, internal_reset_n, go, breakpoint_unit} = 5'h0;
    {irq_test_voltage, irq_level, trim_programmed} = 3'h2;
    {mode_select_a_pin, mode_select_b_pin, paddr, hdata} = 18'h0;
    {pwdata, fetch_addr, reset_vector, oscillator_trim_value} = 72'hFFFF00;
    cases = '{8'hE4, 8'hC0, 8'h60, 8'h7E, 8'h0F};
    n = $urandom(32'h39A1);
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    for (int k = 0; k < 8; k++)
      rd(8'(k * 4), 32'h0, k == 7);
    a = 16'($urandom);
    apb(1'h1, bme_pkg::OFS_ADDRESS_HIGH, {24'h0, a[15:8]});
    apb(1'h1, bme_pkg::OFS_ADDRESS_LOW, {24'h0, a[7:0]});
    rd(bme_pkg::OFS_ADDRESS_LOW, {24'h0, a[7:0]}, 1'h0);
    fetch(a, 0);
    apb(1'h1, bme_pkg::OFS_STATUS_CONTROL, 32'h80);
    fetch(a ^ 16'h0001, 0);
    low_power <= 1'h1;
    fetch(a, 0);
    low_power <= 1'h0;
    fetch(a, 1);
    rd(bme_pkg::OFS_STATUS_CONTROL, 32'hC0, 1'h0);
    apb(1'h1, bme_pkg::OFS_STATUS_CONTROL, 32'h80);
    rd(bme_pkg::OFS_STATUS_CONTROL, 32'h80, 1'h0);
    apb(1'h1, bme_pkg::OFS_STATUS_CONTROL, 32'h40);
    repeat (2) @(posedge pclk);
    `CHK(pulses, 2)
    wait_exit_break <= 1'h1;
    @(posedge pclk);
    wait_exit_break <= 1'h0;
    rd(bme_pkg::OFS_WAIT_STATUS, 32'h2, 1'h0);
    apb(1'h1, bme_pkg::OFS_AUXILIARY, 32'h1);
    break_state <= 1'h1;
    repeat (2) @(posedge pclk);
    `CHK(break_ctrl, 3'h4)
    apb(1'h1, bme_pkg::OFS_FLAG_CONTROL, 32'h80);
    @(posedge pclk);
    `CHK(break_ctrl.flag_clear_allow, 1'h1)
    break_state <= 1'h0;
    trim_programmed <= 1'h1;
    oscillator_trim_value <= 8'($urandom);
    foreach (cases[k])
    begin
      {irq_test_voltage, irq_level, mode_select_a_pin,
        mode_select_b_pin} <= cases[k][7:4];
      reset_vector <= cases[k][3] ? 16'hFFFF : 16'($urandom_range(65534));
      internal_reset_n <= 1'h0;
      @(posedge pclk);
      internal_reset_n <= 1'h1;
      repeat (3) @(posedge pclk);
      me = mon_entry;
      `CHK({me.monitor_mode, me.forced, me.internal_osc}, cases[k][2:0])
      if (cases[k][0])
        `CHK({me.trim_apply, me.trim_value}, {1'h1, oscillator_trim_value})
    end
    {mode_select_a_pin, mode_select_b_pin} <= 2'h1;
    repeat (2) @(posedge pclk);
    `CHK(mon_entry, me)
    `CHK(break_vector, bme_pkg::VEC_BREAK_MONITOR)
    rd(bme_pkg::OFS_MONITOR_STATUS, 32'h7, 1'h0);
    break_state <= 1'h1;
    repeat (2) @(posedge pclk);
    `CHK(break_ctrl, 3'h7)
    break_state <= 1'h0;
    for (int k = 0; k < 7; k++)
      send(8'($urandom), 1'h0);
    fork
      send(8'($urandom), 1'h0);
      meas(f, n);
    join
    `CHK(f, 1'h0)
    `CHK(n inside {[3348:3352]}, 1'h1)
    rd(bme_pkg::OFS_MONITOR_STATUS, 32'hF, 1'h0);
    fork
      send(8'h00, 1'h1);
      meas(f, n);
    join
    `CHK(f, 1'h1)
    `CHK(n inside {[3348:3352]}, 1'h1)
    print_verdict();
  end
endmodule
bind bme_top bme_top_sva u_sva (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .fetch_addr, .fetch_valid,
  .low_power, .break_state, .breakpoint_signal, .force_swi,
  .break_vector, .break_ctrl, .internal_reset_n, .mon_entry,
  .serial_out, .serial_oe);
